// >>> wake_pkg.sv
package wake_pkg;

  // register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] MAC_CTRL_OFS    = 8'h00;
  localparam logic [7:0] WAKE_FILTER_OFS = 8'h28;
  localparam logic [7:0] PM_CTRL_OFS     = 8'h2C;
  localparam logic [7:0] STA_ADDR_HI_OFS = 8'h40;
  localparam logic [7:0] STA_ADDR_LO_OFS = 8'h44;

  // mac_control_reg fields
  localparam int RX_ENABLE_BIT = 2;
  localparam int TX_ENABLE_BIT = 3;

  // pm_control_status_reg fields
  localparam int PD_BIT         = 0;
  localparam int PAT_EN_BIT     = 1;
  localparam int WF_EN_BIT      = 2;
  localparam int PAT_RCVD_BIT   = 5;
  localparam int WF_RCVD_BIT    = 6;
  localparam int PAT_IRQ_EN_BIT = 8;
  localparam int WF_IRQ_EN_BIT  = 9;

  // wake filter word layout
  localparam int           FILTERS       = 4;
  localparam int           FILTER_WORDS  = 8;
  localparam logic [2:0]   CMD_WORD      = 3'd4;
  localparam logic [2:0]   OFS_WORD      = 3'd5;
  localparam logic [2:0]   CRC_WORD_LO   = 3'd6;
  localparam logic [31:0]  CMD_WORD_MASK = 32'h0F0F0F0F;
  localparam int           MASK_BITS     = 31;
  localparam int           CMD_EN_BIT    = 0;
  localparam int           CMD_MCAST_BIT = 3;

  // reset values
  localparam logic [31:0] MAC_CTRL_RST = 32'h00000000;
  localparam logic [31:0] PM_CTRL_RST  = 32'h00000000;
  localparam logic [47:0] STA_ADDR_RST = 48'h000000000000;
  localparam logic [31:0] WORD_RST     = 32'h00000000;

  // frame checks
  localparam logic [10:0] MIN_FRAME_BYTES = 11'd64;
  localparam logic [10:0] HDR_FCS_BYTES   = 11'd18;
  localparam logic [10:0] TYPE_HI_IDX     = 11'd12;
  localparam logic [10:0] TYPE_LO_IDX     = 11'd13;
  localparam logic [10:0] ADDR_FIELD_END  = 11'd12;
  localparam logic [15:0] LEN_TYPE_LIMIT  = 16'h0600;
  localparam logic [31:0] CRC32_INIT      = 32'hFFFFFFFF;
  localparam logic [31:0] CRC32_RESIDUE   = 32'hDEBB20E3;
  localparam logic [31:0] CRC32_POLY      = 32'hEDB88320;
  localparam logic [15:0] CRC16_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC16_POLY      = 16'hA001;

  // pattern frame
  localparam logic [2:0] PAT_SYNC_BYTES = 3'd6;
  localparam logic [6:0] PAT_ADDR_BYTES = 7'd96;
  localparam logic [7:0] ALL_ONES_BYTE  = 8'hFF;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       col;
  } mii_rx_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       last;
  } app_rx_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_FRAME = 2'b01,
    RX_DROP  = 2'b10
  } rx_state_t;

endpackage

// >>> mac_wakeup_frame_detector.sv
// Function
// - power-down drops every received frame
// - eight sequential writes fill filter words
// - eight sequential reads return filter words
// - mask bit j selects byte offset+j
// - command bit 3 picks multicast or unicast
// - command bit 0 enables filter
// - 8-bit offset per filter, minimum 12; offsets below 12 are accepted and not rejected
// - 16-bit expected CRC per filter
// - enabled filter CRC match gives wake frame
// - reject length, FCS, dribble, error, collision, runt
// - wake frame: leave sleep, set bit 6
// - pattern detection only when enabled
// - six FF bytes then address sixteen times
// - check every frame for station in sleep
// - pattern frame sets status, optional interrupt
// - event line and receiver enable needed
// - either wake frame clears power-down
// - status read clears both received bits
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
module mac_wakeup_frame_detector (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 mii_rx_clk,
  input  wire wake_pkg::mii_rx_t    mii_in,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  output wake_pkg::app_rx_t         app_rx,
  output logic                      wake_event,
  output logic                      pm_irq
);
  import wake_pkg::*;

  function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC32_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] sta_byte(input logic [47:0] a, input logic [2:0] i);
    return a[8'(47 - 8 * i) -: 8];
  endfunction

  // link side synchronisers
  logic              rxclk_s1_q, rxclk_s2_q, rxclk_s3_q;
  mii_rx_t           mii_s1_q, mii_s2_q;
  always_ff @(posedge sys_clk) begin
    rxclk_s1_q <= mii_rx_clk;
    rxclk_s2_q <= rxclk_s1_q;
    rxclk_s3_q <= rxclk_s2_q;
    mii_s1_q   <= mii_in;
    mii_s2_q   <= mii_s1_q;
  end
  logic rx_edge;
  assign rx_edge = rxclk_s2_q & ~rxclk_s3_q;

  // registers
  logic [31:0] mac_ctrl_q, pm_ctrl_q;
  logic [47:0] sta_addr_q;
  logic [31:0] wf_mem [FILTER_WORDS];
  logic [2:0]  wf_ptr_q;
  logic        wf_hit, pm_hit;
  logic        wf_accept_q, pat_accept_q;
  assign wf_hit = (reg_addr == WAKE_FILTER_OFS);
  assign pm_hit = (reg_addr == PM_CTRL_OFS);

  // nibble assembly and frame tracking
  rx_state_t   rx_state_q;
  logic [3:0]  nib_lo_q;
  logic        half_q, byte_stb_q, frame_end_q, err_seen_q, dribble_q;
  logic [7:0]  byte_q;
  logic [10:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    byte_stb_q  <= 1'b0;
    frame_end_q <= 1'b0;
    if (rst) begin
      rx_state_q <= RX_IDLE;
      half_q     <= 1'b0;
      nib_lo_q   <= 4'h0;
      byte_q     <= 8'h00;
      err_seen_q <= 1'b0;
      dribble_q  <= 1'b0;
    end else if (rx_edge) begin
      case (rx_state_q)
        RX_IDLE: begin
          if (mii_s2_q.rx_dv) begin
            rx_state_q <= mac_ctrl_q[RX_ENABLE_BIT] ? RX_FRAME : RX_DROP;
            nib_lo_q   <= mii_s2_q.rxd;
            half_q     <= 1'b1;
            err_seen_q <= mii_s2_q.rx_er | mii_s2_q.col;
          end
        end
        RX_FRAME: begin
          if (!mii_s2_q.rx_dv) begin
            rx_state_q  <= RX_IDLE;
            frame_end_q <= 1'b1;
            dribble_q   <= half_q;
            half_q      <= 1'b0;
          end else begin
            err_seen_q <= err_seen_q | mii_s2_q.rx_er | mii_s2_q.col;
            if (half_q) begin
              byte_q     <= {mii_s2_q.rxd, nib_lo_q};
              byte_stb_q <= 1'b1;
            end else begin
              nib_lo_q <= mii_s2_q.rxd;
            end
            half_q <= ~half_q;
          end
        end
        RX_DROP: begin
          if (!mii_s2_q.rx_dv) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // byte index, frame CRC, address and length checks
  logic [31:0] fcs_q;
  logic [15:0] len_q;
  logic        da_sta_q, da_bc_q, mcast_q;
  always_ff @(posedge sys_clk) begin
    if (rst || (rx_edge && rx_state_q == RX_IDLE)) begin
      cnt_q    <= 11'd0;
      fcs_q    <= CRC32_INIT;
      len_q    <= 16'h0000;
      da_sta_q <= 1'b1;
      da_bc_q  <= 1'b1;
      mcast_q  <= 1'b0;
    end else if (byte_stb_q) begin
      cnt_q <= cnt_q + 11'd1;
      fcs_q <= crc32_byte(fcs_q, byte_q);
      if (cnt_q < 11'd6) begin
        da_sta_q <= da_sta_q & (byte_q == sta_byte(sta_addr_q, cnt_q[2:0]));
        da_bc_q  <= da_bc_q & (byte_q == ALL_ONES_BYTE);
      end
      if (cnt_q == 11'd0) begin
        mcast_q <= byte_q[0];
      end
      if (cnt_q == TYPE_HI_IDX) begin
        len_q[15:8] <= byte_q;
      end
      if (cnt_q == TYPE_LO_IDX) begin
        len_q[7:0] <= byte_q;
      end
    end
  end

  logic frame_ok, len_err;
  assign len_err  = (len_q < LEN_TYPE_LIMIT) && (cnt_q >= HDR_FCS_BYTES) &&
                    ({5'b00000, cnt_q - HDR_FCS_BYTES} < len_q);
  assign frame_ok = (fcs_q == CRC32_RESIDUE) && !dribble_q && !err_seen_q &&
                    (cnt_q >= MIN_FRAME_BYTES) && !len_err;

  // four CRC-16 byte-mask filters
  logic [FILTERS-1:0] filt_match;
  generate
    for (genvar i = 0; i < FILTERS; i++) begin : g_filt
      logic [15:0] crc_q;
      logic [30:0] mask;
      logic [3:0]  cmd;
      logic [7:0]  ofs;
      logic [15:0] exp_crc;
      logic [10:0] rel;
      assign mask    = wf_mem[i][MASK_BITS-1:0];
      assign cmd     = wf_mem[CMD_WORD][8*i +: 4];
      assign ofs     = wf_mem[OFS_WORD][8*i +: 8];
      assign exp_crc = wf_mem[CRC_WORD_LO + 3'(i / 2)][16*(i % 2) +: 16];
      assign rel     = cnt_q - {3'b000, ofs};
      always_ff @(posedge sys_clk) begin
        if (rst || (rx_edge && rx_state_q == RX_IDLE)) begin
          crc_q <= CRC16_INIT;
        end else if (byte_stb_q && cnt_q >= {3'b000, ofs} && rel < 11'(MASK_BITS)) begin
          if (mask[rel[4:0]]) begin
            crc_q <= crc16_byte(crc_q, byte_q);
          end
        end
      end
      assign filt_match[i] = cmd[CMD_EN_BIT] &&
                             (cmd[CMD_MCAST_BIT] ? mcast_q : !mcast_q) &&
                             (crc_q == exp_crc);
    end
  endgenerate

  // pattern frame search: six sync bytes then station address 16 times
  logic [2:0] ff_cnt_q;
  logic [6:0] pat_pos_q;
  logic       pat_found_q;
  logic [7:0] pat_exp;
  assign pat_exp = sta_byte(sta_addr_q, 3'(pat_pos_q % 7'd6));
  always_ff @(posedge sys_clk) begin
    if (rst || (rx_edge && rx_state_q == RX_IDLE)) begin
      ff_cnt_q    <= 3'd0;
      pat_pos_q   <= 7'd0;
      pat_found_q <= 1'b0;
    end else if (byte_stb_q && cnt_q >= ADDR_FIELD_END && !pat_found_q) begin
      if (ff_cnt_q == PAT_SYNC_BYTES && byte_q == pat_exp) begin
        pat_pos_q <= pat_pos_q + 7'd1;
        if (pat_pos_q == PAT_ADDR_BYTES - 7'd1) begin
          pat_found_q <= 1'b1;
        end
      end else begin
        pat_pos_q <= 7'd0;
        if (byte_q != ALL_ONES_BYTE) begin
          ff_cnt_q <= 3'd0;
        end else if (ff_cnt_q != PAT_SYNC_BYTES) begin
          ff_cnt_q <= ff_cnt_q + 3'd1;
        end
      end
    end
  end

  // acceptance at end of frame, only while powered down
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wf_accept_q  <= 1'b0;
      pat_accept_q <= 1'b0;
    end else begin
      wf_accept_q  <= frame_end_q && frame_ok && pm_ctrl_q[PD_BIT] && pm_ctrl_q[WF_EN_BIT] &&
                      (|filt_match);
      pat_accept_q <= frame_end_q && frame_ok && pm_ctrl_q[PD_BIT] && pm_ctrl_q[PAT_EN_BIT] &&
                      pat_found_q && (da_sta_q || da_bc_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= wf_accept_q | pat_accept_q;
    end
  end

  // application receive path, blocked in power-down
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      app_rx <= '0;
    end else begin
      app_rx.valid <= byte_stb_q && !pm_ctrl_q[PD_BIT];
      app_rx.last  <= frame_end_q && !pm_ctrl_q[PD_BIT];
      app_rx.data  <= byte_q;
    end
  end

  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mac_ctrl_q <= MAC_CTRL_RST;
      sta_addr_q <= STA_ADDR_RST;
    end else if (reg_wr) begin
      if (reg_addr == MAC_CTRL_OFS) begin
        mac_ctrl_q <= reg_wdata;
      end
      if (reg_addr == STA_ADDR_HI_OFS) begin
        sta_addr_q[47:32] <= reg_wdata[15:0];
      end
      if (reg_addr == STA_ADDR_LO_OFS) begin
        sta_addr_q[31:0] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wf_ptr_q <= 3'd0;
      for (int w = 0; w < FILTER_WORDS; w++) begin
        wf_mem[w] <= WORD_RST;
      end
    end else if ((reg_wr || reg_rd) && wf_hit) begin
      wf_ptr_q <= wf_ptr_q + 3'd1;
      if (reg_wr) begin
        wf_mem[wf_ptr_q] <= (wf_ptr_q == CMD_WORD) ? (reg_wdata & CMD_WORD_MASK) : reg_wdata;
      end
    end
  end

  // power management control and status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pm_ctrl_q <= PM_CTRL_RST;
    end else begin
      if (reg_wr && pm_hit) begin
        pm_ctrl_q[PD_BIT]         <= reg_wdata[PD_BIT];
        pm_ctrl_q[PAT_EN_BIT]     <= reg_wdata[PAT_EN_BIT];
        pm_ctrl_q[WF_EN_BIT]      <= reg_wdata[WF_EN_BIT];
        pm_ctrl_q[PAT_IRQ_EN_BIT] <= reg_wdata[PAT_IRQ_EN_BIT];
        pm_ctrl_q[WF_IRQ_EN_BIT]  <= reg_wdata[WF_IRQ_EN_BIT];
      end
      if (reg_rd && pm_hit) begin
        pm_ctrl_q[WF_RCVD_BIT]  <= 1'b0;
        pm_ctrl_q[PAT_RCVD_BIT] <= 1'b0;
      end
      if (wf_accept_q) begin
        pm_ctrl_q[WF_RCVD_BIT] <= 1'b1;
      end
      if (pat_accept_q) begin
        pm_ctrl_q[PAT_RCVD_BIT] <= 1'b1;
      end
      if (wf_accept_q || pat_accept_q) begin
        pm_ctrl_q[PD_BIT] <= 1'b0;
      end
    end
  end

  assign pm_irq = (pm_ctrl_q[WF_RCVD_BIT] & pm_ctrl_q[WF_IRQ_EN_BIT]) |
                  (pm_ctrl_q[PAT_RCVD_BIT] & pm_ctrl_q[PAT_IRQ_EN_BIT]);

  // register reads, data in the following cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        MAC_CTRL_OFS:    reg_rdata <= mac_ctrl_q;
        WAKE_FILTER_OFS: reg_rdata <= wf_mem[wf_ptr_q];
        PM_CTRL_OFS:     reg_rdata <= pm_ctrl_q;
        STA_ADDR_HI_OFS: reg_rdata <= {16'h0000, sta_addr_q[47:32]};
        STA_ADDR_LO_OFS: reg_rdata <= sta_addr_q[31:0];
        default:         reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  drop_in_pd_a: assert property (app_rx.valid |-> !$past(pm_ctrl_q[PD_BIT]))
    else $error("frame byte forwarded in power-down");
  filt_ptr_a: assert property ((reg_wr && wf_hit) |=> wf_ptr_q == $past(wf_ptr_q) + 3'd1)
    else $error("filter pointer did not advance on write");
  filt_read_a: assert property ((reg_rd && wf_hit) |=> reg_rdata == $past(wf_mem[wf_ptr_q]))
    else $error("filter read returned wrong word");
  filt_off_a: assert property (!wf_mem[CMD_WORD][CMD_EN_BIT] |-> !filt_match[0])
    else $error("disabled filter matched");
  wf_status_a: assert property (wf_accept_q |=> pm_ctrl_q[WF_RCVD_BIT] && !pm_ctrl_q[PD_BIT])
    else $error("wake frame did not set status or leave power-down");
  pat_gate_a: assert property (pat_accept_q |-> $past(pm_ctrl_q[PAT_EN_BIT]) && $past(pat_found_q))
    else $error("pattern accepted while disabled");
  read_clear_a: assert property ((reg_rd && pm_hit && !wf_accept_q && !pat_accept_q) |=>
                                 !pm_ctrl_q[WF_RCVD_BIT] && !pm_ctrl_q[PAT_RCVD_BIT])
    else $error("status read did not clear received bits");
  wake_pulse_a: assert property (wake_event |=> !wake_event)
    else $error("wake event longer than one cycle");
  wake_cause_a: assert property (wake_event |-> $past(wf_accept_q || pat_accept_q) && !pm_ctrl_q[PD_BIT])
    else $error("wake event without accepted frame");

  wake_filter_c: cover property (wf_accept_q ##[1:4] wake_event);
  wake_pattern_c: cover property (pat_accept_q ##1 pm_ctrl_q[PAT_RCVD_BIT]);
  status_ack_c: cover property (pm_ctrl_q[WF_RCVD_BIT] && reg_rd && pm_hit);

endmodule

// >>> mii_phy_model.sv
`timescale 1ns/100ps
module mii_phy_model
  import wake_pkg::*;
(
  output logic             mii_rx_clk,
  output wake_pkg::mii_rx_t mii_in
);
  initial begin
    mii_rx_clk = 1'b0;
    mii_in     = '0;
  end

  // rx clock runs within a frame and for two cycles after it; data changes on the falling edge
  task automatic send_frame(input logic [7:0] b[$]);
    logic [3:0] nib;
    int         i;
    nib = 4'h0;
    for (i = 0; i < 2 * b.size(); i++) begin
      nib = i[0] ? b[i / 2][7:4] : b[i / 2][3:0];
      mii_in.rxd   = nib;
      mii_in.rx_dv = 1'b1;
      #100 mii_rx_clk = 1'b1;
      #100 mii_rx_clk = 1'b0;
    end
    // released data line shows the inverse of the last nibble
    mii_in.rx_dv = 1'b0;
    mii_in.rxd   = ~nib;
    repeat (2) begin
      #100 mii_rx_clk = 1'b1;
      #100 mii_rx_clk = 1'b0;
    end
  endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import wake_pkg::*;
  logic              sys_clk;
  logic              rst;
  logic              mii_rx_clk;
  mii_rx_t           mii_in;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  app_rx_t           app_rx;
  logic              wake_event;
  logic              pm_irq;
  int                fails;
  int                checked;
  int                cycles;
  int                wake_cnt;
  int                app_cnt;
  int                app_sum;
  int                app_last;
  int                s0;
  int                l0;
  int                exp_sum;
  logic [31:0]       mac_val;
  logic [7:0]        frm[$];
  logic [31:0]       d;
  int                i;
  localparam logic [47:0] STATION = 48'h02A45C19E730;

  mac_wakeup_frame_detector mac_wakeup_frame_detector_inst (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .mii_rx_clk (mii_rx_clk),
    .mii_in     (mii_in),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .app_rx     (app_rx),
    .wake_event (wake_event),
    .pm_irq     (pm_irq)
  );

  mii_phy_model mii_phy_model_inst (
    .mii_rx_clk (mii_rx_clk),
    .mii_in     (mii_in)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (wake_event === 1'b1) wake_cnt++;
    if (app_rx.valid === 1'b1) begin
      app_cnt++;
      app_sum += app_rx.data;
    end
    if (app_rx.last === 1'b1) app_last++;
    if (cycles == 60000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // frame from destination address on; bad 1 corrupts the checksum, bad 2 makes a runt
  task automatic build(input bit pat, input bit other, input logic [1:0] bad);
    logic [31:0] c;
    int          k;
    frm.delete();
    for (k = 5; k >= 0; k--) frm.push_back(other ? 8'h07 : STATION[8 * k +: 8]);
    repeat (6) frm.push_back(8'h3C);
    frm.push_back(8'h08);
    frm.push_back(8'h00);
    if (pat) begin
      repeat (6) frm.push_back(8'hFF);
      repeat (16) for (k = 5; k >= 0; k--) frm.push_back(STATION[8 * k +: 8]);
    end
    while (frm.size() < ((bad == 2'd2) ? 40 : 60)) frm.push_back(8'(frm.size()));
    c = CRC32_INIT;
    foreach (frm[k]) begin
      c = c ^ {24'h000000, frm[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC32_POLY : c >> 1;
    end
    c = ~c;
    for (k = 0; k < 4; k++) frm.push_back(c[8 * k +: 8]);
    if (bad == 2'd1) frm[$] = frm[$] ^ 8'h01;
  endtask

  // crc over frame bytes 12..15, the bytes that filter 0 selects
  function automatic logic [15:0] crc16_sel();
    logic [15:0] c;
    int          k;
    c = CRC16_INIT;
    for (k = 12; k < 16; k++) begin
      c = c ^ {8'h00, frm[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC16_POLY : c >> 1;
    end
    return c;
  endfunction

  task automatic load_filters(input logic [3:0] cmd, input logic [15:0] crc);
    reg_write(WAKE_FILTER_OFS, 32'h0000000F);
    repeat (3) reg_write(WAKE_FILTER_OFS, 32'h00000000);
    reg_write(WAKE_FILTER_OFS, {28'h0000000, cmd});
    reg_write(WAKE_FILTER_OFS, 32'h0C0C0C0C);
    reg_write(WAKE_FILTER_OFS, {16'h0000, crc});
    reg_write(WAKE_FILTER_OFS, 32'h00000000);
  endtask

  task automatic run_case(input bit pat, input bit other, input logic [1:0] bad, input logic [3:0] cmd,
                          input bit crcx, input bit exp);
    logic [31:0] en;
    logic [31:0] v;
    logic [31:0] ev;
    int          w0;
    int          a0;
    int          l1;
    build(pat, other, bad);
    load_filters(cmd, crc16_sel() ^ {15'h0000, crcx});
    en = pat ? (32'h1 << PAT_EN_BIT) | (32'h1 << PAT_IRQ_EN_BIT) : (32'h1 << WF_EN_BIT) | (32'h1 << WF_IRQ_EN_BIT);
    reg_write(MAC_CTRL_OFS, 32'h00000000);
    reg_write(PM_CTRL_OFS, en);
    reg_write(PM_CTRL_OFS, en | (32'h1 << PD_BIT));
    reg_write(MAC_CTRL_OFS, mac_val);
    w0 = wake_cnt;
    a0 = app_cnt;
    l1 = app_last;
    mii_phy_model_inst.send_frame(frm);
    repeat (20) @(posedge sys_clk);
    chk(32'(wake_cnt - w0), {31'h0, exp}, "wake pulses");
    chk({31'h0, pm_irq}, {31'h0, exp}, "irq level");
    chk(32'(app_cnt - a0), 32'h00000000, "bytes passed in sleep");
    chk(32'(app_last - l1), 32'h00000000, "frame end in sleep");
    ev = exp ? en | (32'h1 << (pat ? PAT_RCVD_BIT : WF_RCVD_BIT)) : en | (32'h1 << PD_BIT);
    reg_read(PM_CTRL_OFS, v);
    chk(v, ev, "pm status");
    reg_read(PM_CTRL_OFS, v);
    chk({29'h0, v[WF_RCVD_BIT], v[PAT_RCVD_BIT], pm_irq}, 32'h00000000, "status after read");
    reg_write(PM_CTRL_OFS, 32'h00000000);
    reg_write(MAC_CTRL_OFS, mac_val | (32'h1 << TX_ENABLE_BIT));
  endtask

  initial begin
    rst       = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(PM_CTRL_OFS, d);
    chk(d, PM_CTRL_RST, "pm reset");
    reg_write(8'hF0, 32'hFFFFFFFF);
    reg_read(8'hF0, d);
    chk(d, 32'h00000000, "unmapped");
    for (i = 0; i < 8; i++) reg_write(WAKE_FILTER_OFS, 32'h8A5C3E00 | i);
    for (i = 0; i < 8; i++) begin
      reg_read(WAKE_FILTER_OFS, d);
      chk(d, (i == 4) ? (32'h8A5C3E04 & CMD_WORD_MASK) : (32'h8A5C3E00 | i), "filter word");
    end
    reg_write(STA_ADDR_HI_OFS, {16'h0000, STATION[47:32]});
    reg_write(STA_ADDR_LO_OFS, STATION[31:0]);
    mac_val = 32'h1 << RX_ENABLE_BIT;
    reg_write(MAC_CTRL_OFS, mac_val);
    build(1'b0, 1'b0, 2'd0);
    exp_sum = 0;
    foreach (frm[k]) exp_sum += frm[k];
    i = app_cnt;
    s0 = app_sum;
    l0 = app_last;
    mii_phy_model_inst.send_frame(frm);
    repeat (20) @(posedge sys_clk);
    chk(32'(app_cnt - i), 32'h00000040, "bytes passed awake");
    chk(32'(app_sum - s0), 32'(exp_sum), "byte data awake");
    chk(32'(app_last - l0), 32'h00000001, "frame end awake");
    run_case(1'b0, 1'b0, 2'd0, 4'h1, 1'b0, 1'b1);
    run_case(1'b0, 1'b0, 2'd1, 4'h1, 1'b0, 1'b0);
    run_case(1'b0, 1'b0, 2'd2, 4'h1, 1'b0, 1'b0);
    run_case(1'b0, 1'b0, 2'd0, 4'h0, 1'b0, 1'b0);
    run_case(1'b0, 1'b0, 2'd0, 4'h9, 1'b0, 1'b0);
    run_case(1'b0, 1'b1, 2'd0, 4'h9, 1'b0, 1'b1);
    run_case(1'b0, 1'b0, 2'd0, 4'h1, 1'b1, 1'b0);
    run_case(1'b1, 1'b0, 2'd0, 4'h0, 1'b0, 1'b1);
    run_case(1'b1, 1'b1, 2'd0, 4'h0, 1'b0, 1'b0);
    mac_val = 32'h00000000;
    run_case(1'b1, 1'b0, 2'd0, 4'h0, 1'b0, 1'b0);
    stop_test();
  end
endmodule
